// >>> src/rcw_params.svh
`ifndef RCW_PARAMS_SVH
`define RCW_PARAMS_SVH
`define RCW_OFS_CFG 3'h0
`define RCW_OFS_ALM 3'h1
`define RCW_OFS_TWIN 3'h2
`define RCW_OFS_AWIN 3'h3
`define RCW_OFS_PAD 3'h4
`define RCW_OFS_KEY 3'h5
`define RCW_CFG_EN 15
`define RCW_CFG_WREN 13
`define RCW_CFG_OE 10
`define RCW_ALM_EN 15
`define RCW_ALM_CHIME 14
`define RCW_PAD_SEL 1
`define RCW_KEY1 16'h0055
`define RCW_KEY2 16'h00aa
`define RCW_CLK_NS 10
`define RCW_INSTR_NS 40
`define RCW_UNLOCK_CYC (`RCW_INSTR_NS / `RCW_CLK_NS)
`define RCW_HALF_SEC_MS 500
`define RCW_HALF_SEC_CYC (`RCW_HALF_SEC_MS * 1000000 / `RCW_CLK_NS)
`define RCW_DAY_RST 8'h01
`define RCW_MON_RST 8'h01
`define RCW_FIELD_RST 8'h00
`endif

// >>> src/rcw_pkg.sv
package rcw_pkg;
	typedef enum logic [1:0] {
		RCW_KEY_IDLE = 2'b00,
		RCW_KEY_ONE = 2'b01
	} rcw_key_type;
endpackage

// >>> src/rcw_top.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "rcw_params.svh"
// Contract
// - Keep half seconds, h/m/s, day/month/year.
// - Hours run in 24-hour form.
// - Weekday and leap years automatic, 2000-2099.
// - All time fields are BCD digits.
// - Timekeeping ignores the external reset pin.
// - Time pointer selects time window pair.
// - High-byte time write decrements pointer, floor 00.
// - Alarm pointer selects alarm window pair.
// - High-byte alarm write decrements pointer, floor 00.
// - Any alarm window read decrements pointer.
// - Any time window read decrements pointer.
// - Low-byte-only writes keep the pointer.
// - Time writes ignored unless write enable set.
// - Write enable settable only just after unlock.
// - Source select picks seconds clock or alarm.
// - Pin drives only with output enable set.
// - Output enable clear disables the pin.
module rcw_top
	import rcw_pkg::*;
#(
	parameter int unsigned HALF_SEC_CYC = `RCW_HALF_SEC_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ext_reset_pin,
	input wire logic [2:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [15:0] i_avs_writedata,
	input wire logic [1:0] i_avs_byteenable,
	output logic [15:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_rtc_pin,
	output logic o_rtc_pin_oe
);
	function automatic logic [1:0] ptr_dec(input logic [1:0] p);
		return (p == 2'b00) ? 2'b00 : p - 2'b01;
	endfunction

	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] max,
		input logic [7:0] first);
		if (v == max) begin
			return {1'b1, first};
		end
		if (v[3:0] == 4'h9) begin
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		end
		return {1'b0, v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
			(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02: return leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

	logic wait_q, wait_d;
	logic [15:0] rdata_q, rdata_d, rd_mux, twin_rd, awin_rd;
	rcw_key_type key_q, key_d;
	logic [2:0] win_q, win_d;
	logic en_q, en_d, wren_q, wren_d, oe_q, oe_d, half_q, half_d;
	logic [1:0] tptr_q, tptr_d, aptr_q, aptr_d, pad_q, pad_d;
	logic [7:0] cal_q, cal_d, arpt_q, arpt_d;
	logic aen_q, aen_d, chime_q, chime_d, apulse_q, apulse_d;
	logic [3:0] amask_q, amask_d;
	logic [31:0] div_q, div_d;
	logic [7:0] sec_q, sec_d, min_q, min_d, hr_q, hr_d, wd_q, wd_d;
	logic [7:0] day_q, day_d, mon_q, mon_d, yr_q, yr_d;
	logic [7:0] asec_q, asec_d, amin_q, amin_d, ahr_q, ahr_d;
	logic [7:0] awd_q, awd_d, aday_q, aday_d, amon_q, amon_d;
	logic pin_d, pin_oe_d, req, acc, wr, tick, match, ns;
	logic [8:0] t;
	logic [15:0] wdat;
	logic [1:0] be;

	assign req = i_avs_read | i_avs_write;
	// The pin reset stalls the bus and clears the unlock sequence; the clock keeps counting.
	assign acc = req && !wait_q && !i_ext_reset_pin;
	assign wr = acc && i_avs_write;
	assign wdat = i_avs_writedata;
	assign be = i_avs_byteenable;
	assign tick = en_q && (div_q == 32'(HALF_SEC_CYC - 1));

	always_comb begin
		case (tptr_q)
			2'b00: twin_rd = {min_q, sec_q};
			2'b01: twin_rd = {wd_q, hr_q};
			2'b10: twin_rd = {mon_q, day_q};
			default: twin_rd = {8'h00, yr_q};
		endcase
		case (aptr_q)
			2'b00: awin_rd = {amin_q, asec_q};
			2'b01: awin_rd = {awd_q, ahr_q};
			2'b10: awin_rd = {amon_q, aday_q};
			default: awin_rd = 16'h0000;
		endcase
		case (i_avs_address)
			`RCW_OFS_CFG: rd_mux = {en_q, 1'b0, wren_q, 1'b0, half_q, oe_q, tptr_q, cal_q};
			`RCW_OFS_ALM: rd_mux = {aen_q, chime_q, amask_q, aptr_q, arpt_q};
			`RCW_OFS_TWIN: rd_mux = twin_rd;
			`RCW_OFS_AWIN: rd_mux = awin_rd;
			`RCW_OFS_PAD: rd_mux = {14'h0000, pad_q};
			default: rd_mux = 16'h0000;
		endcase
	end

	always_comb begin
		wait_d = 1'b1;
		rdata_d = rdata_q;
		key_d = key_q;
		win_d = (win_q != 3'h0) ? win_q - 3'h1 : 3'h0;
		if (req && wait_q && !i_ext_reset_pin) begin
			wait_d = 1'b0;
			rdata_d = rd_mux;
		end
		if (wr && i_avs_address == `RCW_OFS_KEY && be == 2'b11) begin
			if (wdat == `RCW_KEY1) begin
				key_d = RCW_KEY_ONE;
			end else if (key_q == RCW_KEY_ONE && wdat == `RCW_KEY2) begin
				key_d = RCW_KEY_IDLE;
				win_d = 3'(`RCW_UNLOCK_CYC);
			end else begin
				key_d = RCW_KEY_IDLE;
			end
		end
		if (i_ext_reset_pin) begin
			key_d = RCW_KEY_IDLE;
			win_d = 3'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wait_q <= 1'b1;
			rdata_q <= 16'h0000;
			key_q <= RCW_KEY_IDLE;
			win_q <= 3'h0;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			key_q <= key_d;
			win_q <= win_d;
		end
	end

	always_comb begin
		{en_d, wren_d, oe_d, half_d, tptr_d, cal_d} = {en_q, wren_q, oe_q, half_q, tptr_q, cal_q};
		{aen_d, chime_d, amask_d, aptr_d, arpt_d} = {aen_q, chime_q, amask_q, aptr_q, arpt_q};
		{pad_d, apulse_d, div_d} = {pad_q, apulse_q, div_q};
		{sec_d, min_d, hr_d, wd_d, day_d, mon_d, yr_d} =
			{sec_q, min_q, hr_q, wd_q, day_q, mon_q, yr_q};
		{asec_d, amin_d, ahr_d, awd_d, aday_d, amon_d} =
			{asec_q, amin_q, ahr_q, awd_q, aday_q, amon_q};
		t = 9'h000;
		match = 1'b0;
		ns = 1'b0;
		if (en_q) begin
			div_d = tick ? 32'h0 : div_q + 32'h1;
		end
		if (tick) begin
			half_d = ~half_q;
			if (half_q) begin
				t = bcd_step(sec_q, 8'h59, 8'h00);
				sec_d = t[7:0];
				if (t[8]) begin
					t = bcd_step(min_q, 8'h59, 8'h00);
					min_d = t[7:0];
				end
				if (t[8]) begin
					t = bcd_step(hr_q, 8'h23, 8'h00);
					hr_d = t[7:0];
				end
				if (t[8]) begin
					wd_d = (wd_q == 8'h06) ? 8'h00 : wd_q + 8'h01;
					t = bcd_step(day_q, month_days(mon_q, yr_q), 8'h01);
					day_d = t[7:0];
				end
				if (t[8]) begin
					t = bcd_step(mon_q, 8'h12, 8'h01);
					mon_d = t[7:0];
				end
				if (t[8]) begin
					t = bcd_step(yr_q, 8'h99, 8'h00);
					yr_d = t[7:0];
				end
			end
			ns = !half_d;
			case (amask_q)
				4'h0: match = 1'b1;
				4'h1: match = ns;
				4'h2: match = ns && sec_d[3:0] == asec_q[3:0];
				4'h3: match = ns && sec_d == asec_q;
				4'h4: match = ns && sec_d == asec_q && min_d[3:0] == amin_q[3:0];
				4'h5: match = ns && sec_d == asec_q && min_d == amin_q;
				4'h6: match = ns && {sec_d, min_d, hr_d} == {asec_q, amin_q, ahr_q};
				4'h7: match = ns && {sec_d, min_d, hr_d, wd_d} == {asec_q, amin_q, ahr_q, awd_q};
				4'h8: match = ns && {sec_d, min_d, hr_d, day_d} == {asec_q, amin_q, ahr_q, aday_q};
				4'h9: match = ns && {sec_d, min_d, hr_d, day_d, mon_d} ==
					{asec_q, amin_q, ahr_q, aday_q, amon_q};
				default: match = 1'b0;
			endcase
			apulse_d = 1'b0;
		end
		if (acc && i_avs_read) begin
			if (i_avs_address == `RCW_OFS_TWIN) begin
				tptr_d = ptr_dec(tptr_q);
			end
			if (i_avs_address == `RCW_OFS_AWIN) begin
				aptr_d = ptr_dec(aptr_q);
			end
		end
		if (wr) begin
			case (i_avs_address)
				`RCW_OFS_CFG: begin
					if (be[1]) begin
						// set only inside the unlock window.
						wren_d = wdat[`RCW_CFG_WREN] && (wren_q || win_q != 3'h0);
						en_d = wren_q ? wdat[`RCW_CFG_EN] : en_q;
						oe_d = wdat[`RCW_CFG_OE];
						tptr_d = wdat[9:8];
					end
					if (be[0]) begin
						cal_d = wdat[7:0];
					end
				end
				`RCW_OFS_ALM: begin
					if (be[1]) begin
						{aen_d, chime_d, amask_d, aptr_d} = wdat[15:8];
					end
					if (be[0]) begin
						arpt_d = wdat[7:0];
					end
				end
				`RCW_OFS_TWIN: begin
					if (wren_q) begin
						case (tptr_q)
							2'b00: begin
								min_d = be[1] ? wdat[15:8] : min_d;
								if (be[0]) begin
									{sec_d, half_d, div_d} = {wdat[7:0], 1'b0, 32'h0};
								end
							end
							2'b01: {wd_d, hr_d} = {be[1] ? wdat[15:8] : wd_d, be[0] ? wdat[7:0] : hr_d};
							2'b10: {mon_d, day_d} = {be[1] ? wdat[15:8] : mon_d, be[0] ? wdat[7:0] : day_d};
							// high byte at pointer 11 discarded.
							default: yr_d = be[0] ? wdat[7:0] : yr_d;
						endcase
					end
					if (be[1]) begin
						tptr_d = ptr_dec(tptr_q);
					end
				end
				`RCW_OFS_AWIN: begin
					case (aptr_q)
						2'b00: {amin_d, asec_d} = {be[1] ? wdat[15:8] : amin_d, be[0] ? wdat[7:0] : asec_d};
						2'b01: {awd_d, ahr_d} = {be[1] ? wdat[15:8] : awd_d, be[0] ? wdat[7:0] : ahr_d};
						2'b10: {amon_d, aday_d} = {be[1] ? wdat[15:8] : amon_d, be[0] ? wdat[7:0] : aday_d};
						default: ;
					endcase
					if (be[1]) begin
						aptr_d = ptr_dec(aptr_q);
					end
				end
				`RCW_OFS_PAD: pad_d = be[0] ? wdat[1:0] : pad_q;
				default: ;
			endcase
		end
		// Alarm event applied after software so the hardware action is never lost.
		if (tick && aen_q && match) begin
			apulse_d = 1'b1;
			if (arpt_q != 8'h00 || chime_q) begin
				arpt_d = arpt_q - 8'h01;
			end else begin
				aen_d = 1'b0;
			end
		end
		pin_oe_d = oe_q;
		pin_d = oe_q && (pad_q[`RCW_PAD_SEL] ? !half_q : apulse_q);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			{en_q, wren_q, oe_q, half_q, tptr_q, cal_q} <= '0;
			{aen_q, chime_q, amask_q, aptr_q, arpt_q} <= '0;
			{pad_q, apulse_q, div_q, o_rtc_pin, o_rtc_pin_oe} <= '0;
			{sec_q, min_q, hr_q, wd_q, yr_q} <= {5{`RCW_FIELD_RST}};
			{day_q, mon_q} <= {`RCW_DAY_RST, `RCW_MON_RST};
			{asec_q, amin_q, ahr_q, awd_q, aday_q, amon_q} <= {6{`RCW_FIELD_RST}};
		end else begin
			{en_q, wren_q, oe_q, half_q, tptr_q, cal_q} <= {en_d, wren_d, oe_d, half_d, tptr_d, cal_d};
			{aen_q, chime_q, amask_q, aptr_q, arpt_q} <= {aen_d, chime_d, amask_d, aptr_d, arpt_d};
			{pad_q, apulse_q, div_q, o_rtc_pin, o_rtc_pin_oe} <= {pad_d, apulse_d, div_d, pin_d, pin_oe_d};
			{sec_q, min_q, hr_q, wd_q, yr_q} <= {sec_d, min_d, hr_d, wd_d, yr_d};
			{day_q, mon_q} <= {day_d, mon_d};
			{asec_q, amin_q, ahr_q, awd_q, aday_q, amon_q} <= {asec_d, amin_d, ahr_d, awd_d, aday_d, amon_d};
		end
	end

	assign o_avs_readdata = rdata_q;
	assign o_avs_waitrequest = wait_q;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_key2;
		wr && i_avs_address == `RCW_OFS_KEY && be == 2'b11 && wdat == `RCW_KEY2 &&
			key_q == RCW_KEY_ONE && !i_ext_reset_pin;
	endsequence
	sequence s_sec_end;
		tick && half_q && sec_q == 8'h59 && min_q == 8'h59 && !wr;
	endsequence

	AST_UNLOCK_OPENS: assert property (s_key2 |=> win_q == 3'(`RCW_UNLOCK_CYC))
		else $error("unlock window not opened");
	AST_WREN_GATED: assert property ($rose(wren_q) |-> $past(win_q) != 3'h0)
		else $error("write enable set outside unlock window");
	AST_TWIN_READ: assert property (acc && i_avs_read && i_avs_address == `RCW_OFS_TWIN
		|-> o_avs_readdata == $past(twin_rd))
		else $error("time window read data wrong");
	AST_TPTR_RD: assert property (acc && i_avs_read && i_avs_address == `RCW_OFS_TWIN
		|=> tptr_q == ptr_dec($past(tptr_q)))
		else $error("time pointer not decremented on read");
	AST_APTR_RD: assert property (acc && i_avs_read && i_avs_address == `RCW_OFS_AWIN
		|=> aptr_q == ptr_dec($past(aptr_q)))
		else $error("alarm pointer not decremented on read");
	AST_TPTR_WR: assert property (wr && be[1] && i_avs_address == `RCW_OFS_TWIN
		|=> tptr_q == ptr_dec($past(tptr_q)))
		else $error("time pointer not decremented on write");
	AST_LOW_KEEP: assert property (wr && be == 2'b01 && i_avs_address == `RCW_OFS_AWIN
		|=> $stable(aptr_q))
		else $error("low byte write moved alarm pointer");
	AST_LOCKED: assert property (wr && !wren_q && i_avs_address == `RCW_OFS_TWIN && !tick
		|=> $stable(sec_q) && $stable(min_q) && $stable(yr_q))
		else $error("locked time register changed");
	AST_PIN_OFF: assert property (!oe_q |=> !o_rtc_pin && !o_rtc_pin_oe)
		else $error("pin active with output disabled");
	AST_PIN_SEC: assert property (oe_q && pad_q[`RCW_PAD_SEL] |=> o_rtc_pin == !$past(half_q))
		else $error("seconds clock not on pin");
	AST_SEC_WRAP: assert property (s_sec_end |=> sec_q == 8'h00 && min_q == 8'h00 ##1 !half_q)
		else $error("seconds rollover wrong");
	AST_EXT_RUN: assert property (i_ext_reset_pin && en_q && !tick && !wr
		|=> div_q == $past(div_q) + 32'h1)
		else $error("timekeeping stopped under pin reset");
endmodule
`default_nettype wire

// >>> verif/rcw_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rcw_params.svh"
module rcw_top_tb;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_ext_reset_pin = 1'b0;
	logic [2:0] i_avs_address = 3'h0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [15:0] i_avs_writedata = 16'h0000;
	logic [1:0] i_avs_byteenable = 2'h3;
	logic [15:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic o_rtc_pin;
	logic o_rtc_pin_oe;
	logic [15:0] q;
	int n_mismatch = 0;
	int comparisons = 0;

	always #5 i_clk = ~i_clk;

	// A short half second keeps the rollover run to 16 cycles.
	rcw_top #(.HALF_SEC_CYC(4)) dut_u (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ext_reset_pin(i_ext_reset_pin),
		.i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.o_rtc_pin(o_rtc_pin),
		.o_rtc_pin_oe(o_rtc_pin_oe)
	);

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			n_mismatch++;
		end
	endtask

	// The leading edge keeps release and the next request on separate edges.
	task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d,
			input logic [1:0] be);
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_byteenable <= be;
		i_avs_write <= w;
		i_avs_read <= ~w;
		// Only the watchdog ends a wait that never sees waitrequest low.
		do begin
			@(posedge i_clk);
		end while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask

	task automatic w(input logic [2:0] a, input logic [15:0] d);
		acc(1'b1, a, d, 2'h3);
	endtask

	task automatic rchk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e,
			input string nm);
		acc(1'b0, a, 16'h0000, 2'h3);
		chk(nm, q & m, e);
	endtask

	task automatic unlock();
		w(`RCW_OFS_KEY, `RCW_KEY1);
		w(`RCW_OFS_KEY, `RCW_KEY2);
	endtask

	task automatic t_reset();
		rchk(`RCW_OFS_CFG, 16'hffff, 16'h0000, "config");
		rchk(`RCW_OFS_PAD, 16'hffff, 16'h0000, "pad");
		rchk(3'h6, 16'hffff, 16'h0000, "unmapped");
		rchk(`RCW_OFS_KEY, 16'hffff, 16'h0000, "key");
	endtask

	task automatic t_lock();
		w(`RCW_OFS_TWIN, 16'h1234);
		rchk(`RCW_OFS_TWIN, 16'hffff, 16'h0000, "locked time");
		w(`RCW_OFS_KEY, `RCW_KEY1);
		w(`RCW_OFS_KEY, 16'h0011);
		w(`RCW_OFS_KEY, `RCW_KEY2);
		w(`RCW_OFS_CFG, 16'h2000);
		rchk(`RCW_OFS_CFG, 16'h2000, 16'h0000, "broken unlock");
	endtask

	task automatic t_setwin();
		unlock();
		w(`RCW_OFS_CFG, 16'h2300);
		rchk(`RCW_OFS_CFG, 16'h2300, 16'h2300, "wren");
		w(`RCW_OFS_TWIN, 16'h0024);
		w(`RCW_OFS_TWIN, 16'h0228);
		w(`RCW_OFS_TWIN, 16'h0223);
		w(`RCW_OFS_TWIN, 16'h5958);
		rchk(`RCW_OFS_CFG, 16'h0300, 16'h0000, "ptr floor");
		w(`RCW_OFS_CFG, 16'h0300);
		rchk(`RCW_OFS_TWIN, 16'hffff, 16'h0024, "year");
		rchk(`RCW_OFS_TWIN, 16'hffff, 16'h0228, "mon day");
		rchk(`RCW_OFS_TWIN, 16'hffff, 16'h0223, "wd hr");
		rchk(`RCW_OFS_TWIN, 16'hffff, 16'h5958, "min sec");
		rchk(`RCW_OFS_TWIN, 16'hffff, 16'h5958, "min sec again");
	endtask

	task automatic t_bytes();
		w(`RCW_OFS_CFG, 16'h0200);
		acc(1'b1, `RCW_OFS_TWIN, 16'h0011, 2'h1);
		rchk(`RCW_OFS_CFG, 16'h0300, 16'h0200, "low write ptr");
		acc(1'b1, `RCW_OFS_TWIN, 16'h0000, 2'h2);
		rchk(`RCW_OFS_CFG, 16'h0300, 16'h0100, "high write ptr");
		rchk(`RCW_OFS_TWIN, 16'hffff, 16'h0223, "locked wd hr");
	endtask

	task automatic t_alarm();
		w(`RCW_OFS_ALM, 16'h0300);
		rchk(`RCW_OFS_AWIN, 16'hffff, 16'h0000, "alarm slot3");
		rchk(`RCW_OFS_ALM, 16'hffff, 16'h0200, "alarm ptr read");
		w(`RCW_OFS_AWIN, 16'h0312);
		w(`RCW_OFS_AWIN, 16'h0408);
		w(`RCW_OFS_AWIN, 16'h3010);
		rchk(`RCW_OFS_ALM, 16'hffff, 16'h0000, "alarm ptr floor");
		w(`RCW_OFS_ALM, 16'h0200);
		rchk(`RCW_OFS_AWIN, 16'hffff, 16'h0312, "alarm mon day");
		rchk(`RCW_OFS_AWIN, 16'hffff, 16'h0408, "alarm wd hr");
		rchk(`RCW_OFS_AWIN, 16'hffff, 16'h3010, "alarm min sec");
		rchk(`RCW_OFS_AWIN, 16'hffff, 16'h3010, "alarm floor");
		w(`RCW_OFS_ALM, 16'h0100);
		acc(1'b1, `RCW_OFS_AWIN, 16'h0007, 2'h1);
		rchk(`RCW_OFS_ALM, 16'h0300, 16'h0100, "alarm low write ptr");
		rchk(`RCW_OFS_AWIN, 16'hffff, 16'h0407, "alarm low byte");
	endtask

	task automatic t_pin();
		w(`RCW_OFS_PAD, 16'h0002);
		repeat (4) @(posedge i_clk);
		chk("oe off", {15'h0000, o_rtc_pin_oe}, 16'h0000);
		w(`RCW_OFS_CFG, 16'h0400);
		repeat (4) @(posedge i_clk);
		chk("oe on", {15'h0000, o_rtc_pin_oe}, 16'h0001);
		chk("seconds pin", {15'h0000, o_rtc_pin}, 16'h0001);
		w(`RCW_OFS_PAD, 16'h0000);
		repeat (4) @(posedge i_clk);
		chk("alarm pin", {15'h0000, o_rtc_pin}, 16'h0000);
		w(`RCW_OFS_PAD, 16'h0002);
		w(`RCW_OFS_CFG, 16'h0000);
		repeat (4) @(posedge i_clk);
		chk("oe cleared", {15'h0000, o_rtc_pin_oe}, 16'h0000);
		chk("pin cleared", {15'h0000, o_rtc_pin}, 16'h0000);
	endtask

	// Time starts at 23:59:58 on 28 Feb of year 24, so midnight lands on a leap day.
	task automatic t_run();
		unlock();
		w(`RCW_OFS_CFG, 16'h2000);
		w(`RCW_OFS_CFG, 16'ha000);
		@(posedge i_clk);
		i_ext_reset_pin <= 1'b1;
		repeat (48) @(posedge i_clk);
		chk("stall", {15'h0000, o_avs_waitrequest}, 16'h0001);
		i_ext_reset_pin <= 1'b0;
		rchk(`RCW_OFS_CFG, 16'h8000, 16'h8000, "still enabled");
		w(`RCW_OFS_CFG, 16'h8200);
		rchk(`RCW_OFS_TWIN, 16'hffff, 16'h0229, "leap day");
		rchk(`RCW_OFS_TWIN, 16'hffff, 16'h0300, "midnight");
		rchk(`RCW_OFS_TWIN, 16'hff00, 16'h0000, "minutes");
	endtask

	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset();
		t_lock();
		t_setwin();
		t_bytes();
		t_alarm();
		t_pin();
		t_run();
		report_and_stop();
	end

	initial begin
		#50000;
		n_mismatch++;
		report_and_stop();
	end
endmodule
`default_nettype wire
